// >>> logic/stp_pkg.sv
package stp_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX  = 8'h43;
  localparam logic [7:0] SEL_IDX   = 8'h44;
  localparam logic [7:0] PHASE_IDX = 8'h45;
  localparam int         ADDR_W    = 10;

  // general_timer_control fields
  localparam int TSM_BIT  = 7;
  localparam int APSR_BIT = 1;
  localparam int PSR_BIT  = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Tick select register fields
  localparam int SEL_A_LO = 0;
  localparam int SEL_B_LO = 4;
  localparam int SEL_W    = 3;
  localparam logic [2:0] SEL_RST = 3'h0;

  // Tick source select encodings
  localparam logic [2:0] SEL_STOP = 3'h0;
  localparam logic [2:0] SEL_DIV1 = 3'h1;
  localparam logic [2:0] SEL_DIV8 = 3'h2;
  localparam logic [2:0] SEL_D64  = 3'h3;
  localparam logic [2:0] SEL_D256 = 3'h4;
  localparam logic [2:0] SEL_D1K  = 3'h5;
  localparam logic [2:0] SEL_FALL = 3'h6;
  localparam logic [2:0] SEL_RISE = 3'h7;

  // Prescaler width and tap masks
  localparam int          PRE_W     = 10;
  localparam logic [9:0]  PRE_RST   = 10'h000;
  localparam logic [9:0]  MASK_D8   = 10'h007;
  localparam logic [9:0]  MASK_D64  = 10'h03f;
  localparam logic [9:0]  MASK_D256 = 10'h0ff;
  localparam logic [9:0]  MASK_D1K  = 10'h3ff;
endpackage

// >>> logic/stp_pin_sync.sv
`timescale 1ns/1ps
module stp_pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic count_pin,
  output logic      rise,
  output logic      fall
);
  logic pin_lat;
  logic samp_ff;
  logic prev_ff;
  logic nxt_samp;
  logic nxt_prev;

  // Latch open in the high clock phase gives the half cycle of latency
  always_latch begin
    if (clk) begin
      pin_lat = count_pin;
    end
  end

  // One sample per clock, then the previous sample for comparison
  always_comb begin
    nxt_samp = pin_lat;
    nxt_prev = samp_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      samp_ff <= nxt_samp;
      prev_ff <= nxt_prev;
    end
  end

  // Edge flags from current against previous sample
  assign rise = samp_ff & ~prev_ff;
  assign fall = ~samp_ff & prev_ff;

  chk_pin_edge_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(count_pin) |-> ##1 rise)
    else $error("pin rise not flagged one cycle later");
endmodule

// >>> logic/stp_prescaler.sv
`timescale 1ns/1ps
module stp_prescaler (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        external_count_pin_a,
  input  wire logic        external_count_pin_b,
  output logic             timer_tick_a,
  output logic             timer_tick_b,
  output logic             async_prescaler_reset
);
  logic                    req;
  logic                    acc;
  logic [7:0]              widx;
  logic                    ack_ff;
  logic                    nxt_ack;
  logic [31:0]             rdata_ff;
  logic [31:0]             nxt_rdata;
  logic                    tsm_ff;
  logic                    nxt_tsm;
  logic                    psr_ff;
  logic                    nxt_psr;
  logic                    apsr_ff;
  logic                    nxt_apsr;
  logic [2:0]              sel_a_ff;
  logic [2:0]              nxt_sel_a;
  logic [2:0]              sel_b_ff;
  logic [2:0]              nxt_sel_b;
  logic [9:0]              pre_cnt_ff;
  logic [9:0]              nxt_pre_cnt;
  logic                    tick_a_ff;
  logic                    nxt_tick_a;
  logic                    tick_b_ff;
  logic                    nxt_tick_b;
  logic                    a_rise;
  logic                    a_fall;
  logic                    b_rise;
  logic                    b_fall;
  logic                    ctrl_wr;
  logic                    sel_wr;

  // Tick decode shared by both timers
  function automatic logic sel_tick(input logic [2:0] sel, input logic [9:0] cnt,
                                    input logic rise, input logic fall);
    logic t;
    t = 1'b0;
    case (sel)
      stp_pkg::SEL_STOP: t = 1'b0;
      stp_pkg::SEL_DIV1: t = 1'b1;
      stp_pkg::SEL_DIV8: t = ((cnt & stp_pkg::MASK_D8) == stp_pkg::MASK_D8);
      stp_pkg::SEL_D64:  t = ((cnt & stp_pkg::MASK_D64) == stp_pkg::MASK_D64);
      stp_pkg::SEL_D256: t = ((cnt & stp_pkg::MASK_D256) == stp_pkg::MASK_D256);
      stp_pkg::SEL_D1K:  t = ((cnt & stp_pkg::MASK_D1K) == stp_pkg::MASK_D1K);
      stp_pkg::SEL_FALL: t = fall;
      stp_pkg::SEL_RISE: t = rise;
      default:           t = 1'b0;
    endcase
    return t;
  endfunction

  // Pin sampling; no direction input, so output pins still count
  stp_pin_sync u_sync_a (
    .clk       (clk),
    .rst_n     (rst_n),
    .count_pin (external_count_pin_a),
    .rise      (a_rise),
    .fall      (a_fall)
  );

  stp_pin_sync u_sync_b (
    .clk       (clk),
    .rst_n     (rst_n),
    .count_pin (external_count_pin_b),
    .rise      (b_rise),
    .fall      (b_fall)
  );

  // Bus decode; one wait state so read data can come from a flop
  assign req         = read | write;
  assign widx        = address[9:2];
  assign acc         = req & ack_ff;
  assign waitrequest = req & ~ack_ff;
  assign ctrl_wr     = acc & write & byteenable[0] & (widx == stp_pkg::CTRL_IDX);
  assign sel_wr      = acc & write & byteenable[0] & (widx == stp_pkg::SEL_IDX);

  // Bus answer next values
  always_comb begin
    nxt_ack   = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (read & ~ack_ff) begin
      case (widx)
        stp_pkg::CTRL_IDX: begin
          nxt_rdata                    = 32'h0000_0000;
          nxt_rdata[stp_pkg::TSM_BIT]  = tsm_ff;
          nxt_rdata[stp_pkg::APSR_BIT] = apsr_ff;
          nxt_rdata[stp_pkg::PSR_BIT]  = psr_ff;
        end
        stp_pkg::SEL_IDX: begin
          nxt_rdata = {24'h00_0000, 1'b0, sel_b_ff, 1'b0, sel_a_ff};
        end
        stp_pkg::PHASE_IDX: begin
          nxt_rdata = {22'h00_0000, pre_cnt_ff}; // Live divider phase
        end
        default: begin
          nxt_rdata = 32'h0000_0000; // Unmapped reads as zero
        end
      endcase
    end
  end

  // Answer flag and read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign readdata = rdata_ff;

  // Control bits; hold mode keeps written reset bits, release clears both
  always_comb begin
    nxt_tsm  = tsm_ff;
    nxt_psr  = psr_ff;
    nxt_apsr = apsr_ff;
    if (ctrl_wr) begin
      nxt_tsm = writedata[stp_pkg::TSM_BIT];
      if (writedata[stp_pkg::TSM_BIT]) begin
        nxt_psr  = writedata[stp_pkg::PSR_BIT];
        nxt_apsr = writedata[stp_pkg::APSR_BIT];
      end else if (tsm_ff) begin
        nxt_psr  = 1'b0;
        nxt_apsr = 1'b0;
      end else begin
        nxt_psr  = writedata[stp_pkg::PSR_BIT];
        nxt_apsr = writedata[stp_pkg::APSR_BIT];
      end
    end else if (!tsm_ff) begin
      nxt_psr  = 1'b0;
      nxt_apsr = 1'b0;
    end
  end

  // Control register bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsm_ff  <= stp_pkg::CTRL_RST[stp_pkg::TSM_BIT];
      psr_ff  <= stp_pkg::CTRL_RST[stp_pkg::PSR_BIT];
      apsr_ff <= stp_pkg::CTRL_RST[stp_pkg::APSR_BIT];
    end else begin
      tsm_ff  <= nxt_tsm;
      psr_ff  <= nxt_psr;
      apsr_ff <= nxt_apsr;
    end
  end

  assign async_prescaler_reset = apsr_ff;

  // Per-timer tick source selects
  always_comb begin
    nxt_sel_a = sel_a_ff;
    nxt_sel_b = sel_b_ff;
    if (sel_wr) begin
      nxt_sel_a = writedata[stp_pkg::SEL_A_LO +: stp_pkg::SEL_W];
      nxt_sel_b = writedata[stp_pkg::SEL_B_LO +: stp_pkg::SEL_W];
    end
  end

  // Select registers; both start stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_a_ff <= stp_pkg::SEL_RST;
      sel_b_ff <= stp_pkg::SEL_RST;
    end else begin
      sel_a_ff <= nxt_sel_a;
      sel_b_ff <= nxt_sel_b;
    end
  end

  // Divider ignores the selects; reset parks it at zero for both timers
  always_comb begin
    if (psr_ff) begin
      nxt_pre_cnt = stp_pkg::PRE_RST;
    end else begin
      nxt_pre_cnt = pre_cnt_ff + 10'h001;
    end
  end

  // Divider count; wraps after 1023 so every tap keeps its period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_ff <= stp_pkg::PRE_RST;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
    end
  end

  // Registered ticks; taps only fire on the all-ones phase, so the
  // first tick after enabling depends on where the divider stands
  always_comb begin
    nxt_tick_a = sel_tick(sel_a_ff, pre_cnt_ff, a_rise, a_fall);
    nxt_tick_b = sel_tick(sel_b_ff, pre_cnt_ff, b_rise, b_fall);
  end

  // Tick flops; costs one cycle but keeps the outputs glitch free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_a_ff <= 1'b0;
      tick_b_ff <= 1'b0;
    end else begin
      tick_a_ff <= nxt_tick_a;
      tick_b_ff <= nxt_tick_b;
    end
  end

  assign timer_tick_a = tick_a_ff;
  assign timer_tick_b = tick_b_ff;

  // All checks share the system clock and the bus reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_div1_every_clk: assert property (
    (sel_a_ff == 3'h1)[*2] |-> timer_tick_a)
    else $error("divide by one missed a tick");

  chk_div8_period: assert property (
    sel_a_ff == stp_pkg::SEL_DIV8
    ##1 timer_tick_a && sel_a_ff == stp_pkg::SEL_DIV8 && !psr_ff
    ##1 (sel_a_ff == stp_pkg::SEL_DIV8 && !psr_ff)[*8] |-> timer_tick_a)
    else $error("divide by eight period wrong");

  chk_div8_no_early: assert property (
    sel_b_ff == stp_pkg::SEL_DIV8 ##1 timer_tick_b && sel_b_ff == stp_pkg::SEL_DIV8
    ##1 (sel_b_ff == stp_pkg::SEL_DIV8)[*7] |-> !timer_tick_b)
    else $error("divide by eight ticked early");

  chk_divider_free_run: assert property (
    !psr_ff |=> pre_cnt_ff == 10'($past(pre_cnt_ff) + 10'h001))
    else $error("divider did not advance");

  chk_reset_restart: assert property (
    psr_ff |=> pre_cnt_ff == 10'h000)
    else $error("divider phase not restarted");

  chk_rise_tick: assert property (
    (sel_a_ff == 3'h7)[*2] |-> timer_tick_a == $past(a_rise))
    else $error("rising edge tick mismatch");

  chk_fall_tick: assert property (
    (sel_b_ff == 3'h6)[*2] |-> timer_tick_b == $past(b_fall))
    else $error("falling edge tick mismatch");

  chk_hold_keeps_reset: assert property (
    tsm_ff && psr_ff && !ctrl_wr |=> psr_ff)
    else $error("held reset bit dropped");

  chk_release_clears: assert property (
    $fell(tsm_ff) |-> !psr_ff && !apsr_ff)
    else $error("release left reset bits set");

  chk_reset_self_clear: assert property (
    psr_ff && !tsm_ff && !ctrl_wr |=> !psr_ff)
    else $error("reset bit not cleared");

  chk_stop_no_tick: assert property (
    (sel_b_ff == 3'h0)[*2] |-> !timer_tick_b)
    else $error("stopped timer ticked");

  chk_bus_one_wait: assert property (
    req && !ack_ff |=> !waitrequest || !req)
    else $error("bus answer late");

  // Tap phase: a prescaled tick only follows the all-ones divider state
  chk_tap64_phase: assert property (
    sel_b_ff == stp_pkg::SEL_D64 ##1 timer_tick_b
    |-> $past(pre_cnt_ff & stp_pkg::MASK_D64) == stp_pkg::MASK_D64)
    else $error("divide by 64 tick off phase");

  chk_tap1k_phase: assert property (
    sel_a_ff == stp_pkg::SEL_D1K ##1 timer_tick_a
    |-> $past(pre_cnt_ff & stp_pkg::MASK_D1K) == stp_pkg::MASK_D1K)
    else $error("divide by 1024 tick off phase");

  chk_stop_silent_a: assert property (
    (sel_a_ff == stp_pkg::SEL_STOP)[*2] |-> !timer_tick_a)
    else $error("stopped timer a ticked");

  // Pin ticks: one pulse per edge, straight from the detector
  chk_pin_bypass: assert property (
    sel_b_ff == stp_pkg::SEL_FALL && b_fall |=> timer_tick_b)
    else $error("falling pin edge gave no tick");

  chk_rise_single_pulse: assert property (
    sel_a_ff == stp_pkg::SEL_RISE ##1 timer_tick_a && sel_a_ff == stp_pkg::SEL_RISE
    |=> !timer_tick_a)
    else $error("rising edge tick longer than one cycle");

  chk_fall_single_pulse: assert property (
    sel_b_ff == stp_pkg::SEL_FALL ##1 timer_tick_b && sel_b_ff == stp_pkg::SEL_FALL
    |=> !timer_tick_b)
    else $error("falling edge tick longer than one cycle");

  // Register side: held bits stay, unheld async bit drops, selects land
  chk_hold_keeps_async: assert property (
    tsm_ff && apsr_ff && !ctrl_wr |=> apsr_ff)
    else $error("held async reset bit dropped");

  chk_async_self_clear: assert property (
    apsr_ff && !tsm_ff && !ctrl_wr |=> !apsr_ff)
    else $error("async reset bit not cleared");

  chk_select_write_lands: assert property (
    sel_wr |=> sel_a_ff == $past(writedata[stp_pkg::SEL_A_LO +: stp_pkg::SEL_W])
           && sel_b_ff == $past(writedata[stp_pkg::SEL_B_LO +: stp_pkg::SEL_W]))
    else $error("tick select write lost");

  cov_hold_release: cover property ($fell(tsm_ff));
  cov_div1k_tick: cover property (sel_a_ff == 3'h5 && timer_tick_a);
  cov_pin_rise: cover property (sel_a_ff == 3'h7 && timer_tick_a);
  cov_pin_fall: cover property (sel_b_ff == 3'h6 && timer_tick_b);
  cov_sync_hold: cover property (tsm_ff && psr_ff && apsr_ff);
endmodule

// >>> testbench/stp_pin_source.sv
`timescale 1ns/1ps
module stp_pin_source (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] half,
  input  wire logic [7:0] pulses,
  output logic            pin
);
  // Pin idles low; each phase lasts half cycles, so half must stay above zero
  initial pin = 1'b0;
  always @(posedge clk) begin
    if (start) begin
      for (int p = 0; p < pulses; p++) begin
        pin <= 1'b1;
        repeat (half) @(posedge clk);
        pin <= 1'b0;
        repeat (half) @(posedge clk);
      end
    end
  end
endmodule

// >>> testbench/shared_timer_prescaler_bench.sv
`timescale 1ns/1ps
module shared_timer_prescaler_bench;
  localparam logic [9:0] CTRL_A = {stp_pkg::CTRL_IDX, 2'b00};
  localparam logic [9:0] SEL_A  = {stp_pkg::SEL_IDX, 2'b00};
  localparam logic [9:0] PH_A   = {stp_pkg::PHASE_IDX, 2'b00};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  address = 10'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        pin;
  logic        start = 1'b0;
  logic [7:0]  pulses = 8'h01;
  logic        tick_a;
  logic        tick_b;
  logic        apr;
  int          n_mismatch = 0;
  int          n_tests = 0;
  logic [31:0] ca; // Four-state, so an unknown tick spoils the count
  logic [31:0] cb;
  int          k;
  int          dv[4] = '{8, 64, 256, 1024};

  // Free running 50 MHz clock
  always #10 clk = ~clk;

  stp_prescaler i_stp_prescaler (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .external_count_pin_a(pin), .external_count_pin_b(pin),
    .timer_tick_a(tick_a), .timer_tick_b(tick_b), .async_prescaler_reset(apr));
  stp_pin_source i_stp_pin_source (.clk(clk), .start(start), .half(4'h3), .pulses(pulses),
    .pin(pin));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    address <= adr;
    write <= wr;
    read <= !wr;
    writedata <= wd;
    byteenable <= 4'hf;
    // Answer read at the edge itself, before that edge's updates land
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] adr, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, adr, d, x);
  endtask

  task automatic rd_chk(input string name, input logic [9:0] adr, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, adr, 32'h0, x);
    chk(name, exp, x);
  endtask

  task automatic sel(input logic [2:0] a, input logic [2:0] b);
    wr(SEL_A, {25'h0, b, 1'b0, a});
  endtask

  // Ticks of both timers over a window of n cycles
  task automatic count(input int n, input int ea, input int eb);
    ca = 0;
    cb = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      ca += 32'(tick_a);
      cb += 32'(tick_b);
    end
    chk("ticks_a", ea, ca);
    chk("ticks_b", eb, cb);
  endtask

  task automatic pulse(input logic [7:0] n);
    @(posedge clk);
    pulses <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well past the roughly 3200 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("control", CTRL_A, 32'h0);
    rd_chk("select", SEL_A, 32'h0);
    rd_chk("unmapped", 10'h000, 32'h0);
    count(40, 0, 0);
    sel(stp_pkg::SEL_DIV1, stp_pkg::SEL_STOP);
    count(16, 16, 0);
    // Any window of two periods holds exactly two ticks, whatever the phase
    for (int i = 0; i < 4; i++) begin
      sel(stp_pkg::SEL_DIV8 + 3'(i), stp_pkg::SEL_DIV8);
      count(2 * dv[i], 2, 2 * dv[i] / 8);
    end
    sel(stp_pkg::SEL_STOP, stp_pkg::SEL_STOP);
    sel(stp_pkg::SEL_D64, stp_pkg::SEL_STOP);
    k = 0;
    while (tick_a !== 1'b1 && k < 80) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("first_tick", 1, k <= 64);
    sel(stp_pkg::SEL_DIV8, stp_pkg::SEL_D64);
    wr(CTRL_A, 32'h01);
    rd_chk("control", CTRL_A, 32'h0);
    wr(CTRL_A, 32'h83);
    rd_chk("control", CTRL_A, 32'h83);
    chk("async_reset", 1, apr);
    rd_chk("phase", PH_A, 32'h0);
    count(128, 0, 0);
    wr(CTRL_A, 32'h00);
    rd_chk("control", CTRL_A, 32'h0);
    chk("async_reset", 0, apr);
    count(64, 8, 1);
    // Select changed only while the pin rests low
    sel(stp_pkg::SEL_RISE, stp_pkg::SEL_FALL);
    pulse(8'h05);
    count(70, 5, 5);
    pulse(8'h01);
    k = 0;
    while (tick_a !== 1'b1 && k < 10) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("pin_latency", 2, k);
    repeat (10) @(posedge clk);
    summarize();
  end
endmodule
